/* File: verilog/hsc_pkg.sv */
// Shared constants for the high-speed system clock control block
package hsc_pkg;

    // Register port geometry
    localparam int          DW = 8;
    localparam int          AW = 3;

    // Register offsets
    localparam logic [2:0]  ADDR_OSC_MODE_CONTROL  = 3'h0;
    localparam logic [2:0]  ADDR_MAIN_OSC_CONTROL  = 3'h1;
    localparam logic [2:0]  ADDR_MAIN_CLOCK_MODE   = 3'h2;
    localparam logic [2:0]  ADDR_CPU_CLOCK_CONTROL = 3'h3;
    localparam logic [2:0]  ADDR_STAB_STATUS       = 3'h4;

    // Field positions
    localparam int          BIT_EXT_INPUT_SEL = 7;
    localparam int          BIT_OSC_PIN_SEL   = 6;
    localparam int          BIT_OSC_GAIN_SEL  = 0;
    localparam int          BIT_HS_CLOCK_STOP = 7;
    localparam int          BIT_MAIN_SRC_SEL  = 2;
    localparam int          BIT_MAIN_SRC_STAT = 1;
    localparam int          BIT_MAIN_CLK_MODE = 0;
    localparam int          BIT_SUB_ACTIVE    = 5;
    localparam int          BIT_CPU_SRC_SEL   = 4;
    localparam int          DIV_MSB           = 2;
    localparam int          DIV_LSB           = 0;

    // Reset values and the highest legal divider code
    localparam logic        RST_HS_CLOCK_STOP = 1'b1;
    localparam logic [2:0]  RST_DIV_CODE      = 3'h1;
    localparam logic [2:0]  DIV_MAX_CODE      = 3'h4;

    // CPU clock hold after the gain bit is raised
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          GAIN_HOLD_NS  = 5000;
    localparam int          GAIN_HOLD_CYC = (GAIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          HOLD_W        = 8;

    // Stabilization counter and status thresholds (powers of two)
    localparam int          STAB_W   = 17;
    localparam int          STAB_E0  = 11;
    localparam int          STAB_E1  = 13;
    localparam int          STAB_E2  = 14;
    localparam int          STAB_E3  = 15;
    localparam int          STAB_E4  = 16;

    // Gain setting progress, Gray along open -> hold -> locked
    typedef enum logic [1:0] {
        HSC_GAIN_OPEN   = 2'b00,
        HSC_GAIN_HOLD   = 2'b01,
        HSC_GAIN_LOCKED = 2'b11
    } hsc_gain_e;

    // Use of the two high-speed clock pins
    typedef enum logic [1:0] {
        HSC_PIN_PORT = 2'b00,
        HSC_PIN_OSC  = 2'b01,
        HSC_PIN_EXT  = 2'b11
    } hsc_pin_e;

    // Only codes 000..100 are legal divider settings
    function automatic logic hsc_div_ok(input logic [2:0] code);
        return code <= DIV_MAX_CODE;
    endfunction

    // Pin use from the two select bits
    function automatic hsc_pin_e hsc_pin_mode(input logic ext_sel, input logic pin_sel);
        if (!pin_sel) begin
            return HSC_PIN_PORT;
        end
        return ext_sel ? HSC_PIN_EXT : HSC_PIN_OSC;
    endfunction

endpackage

/* File: verilog/hsc_cpu_div.sv */
`timescale 1ns/100ps
// Divides the main clock enable by 2**code; ratio changes only at period end
module hsc_cpu_div
    import hsc_pkg::*;
(
    input  wire logic       clock,      // System clock
    input  wire logic       rst_b,      // Async reset, active low
    input  wire logic       main_tick,  // Main clock enable pulse
    input  wire logic [2:0] div_code,   // Requested ratio code
    output logic            div_tick    // Divided enable pulse
);

    typedef struct packed {
        logic [3:0] cnt;
        logic [2:0] code;
        logic       tick;
    } hsc_div_s;

    hsc_div_s s_r;
    hsc_div_s s_nxt;

    // Next state; a new ratio is taken only when a period closes
    always_comb begin
        logic [3:0] last;
        last  = 4'(({3'h0, 1'b1} << s_r.code) - 4'h1);
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (main_tick) begin
            if (s_r.cnt >= last) begin
                s_nxt.cnt  = 4'h0;
                s_nxt.tick = 1'b1;
                s_nxt.code = div_code;  // RL20
            end else begin
                s_nxt.cnt = s_r.cnt + 4'h1;  // RL15
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '{cnt: 4'h0, code: RST_DIV_CODE, tick: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign div_tick = s_r.tick;

    AST_DIV_ON_MAIN: assert property (@(posedge clock) disable iff (!rst_b)  // RL20
        div_tick |-> $past(main_tick))
        else $error("divided tick without a main tick");

endmodule

/* File: verilog/hsc_top.sv */
`timescale 1ns/100ps
// What this block does, and what software must do
// [RL1] Gain bit 0 for 1 to 10 MHz, 1 above 10 up to 20 MHz.
// [RL2] Only the first changing write of the gain bit after reset takes effect.
// [RL3] Raising the gain bit withholds CPU clock for at least 5 us.
// [RL4] Software sets the gain bit before any peripheral setup.
// [RL5] Both clock pins are general-purpose ports after reset.
// [RL6] External-input 0 and pin-select 1 put both pins in oscillator mode.
// [RL7] Both selects 1: pin A stays a port, pin B takes external clock.
// [RL8] Clearing the stop bit starts the oscillator or enables external input.
// [RL9] Software polls stabilization status before using the resonator clock.
// [RL10] Software leaves pin selects alone while the resonator runs.
// [RL11] Software leaves pin selects alone while external clock runs.
// [RL12] Main-source and main-mode both 1 feed high-speed clock to main and peripherals.
// [RL13] High-speed main clock forces high-speed peripheral clock.
// [RL14] CPU-source 0 feeds the CPU from the main clock via the divider.
// [RL15] Divider codes 000..100 give /1,/2,/4,/8,/16; others refused; /2 default.
// [RL16] Stop mode or stop bit halts the oscillator or external input.
// [RL17] After reset the CPU runs from the internal high-speed oscillator.
// [RL18] Status: sub 0 main 0 internal, 0 1 high-speed, sub 1 subsystem.
// [RL19] Software stops high-speed users before setting the stop bit.
// [RL20] Source and ratio changes never shorten a clock pulse.
module hsc_top
    import hsc_pkg::*;
(
    input  wire logic          clock,            // 50 MHz system clock
    input  wire logic          rst_b,            // Async reset, active low
    input  wire logic [AW-1:0] reg_addr,         // Register address
    input  wire logic [DW-1:0] reg_wdata,        // Write data
    input  wire logic          reg_wr,           // Write strobe
    input  wire logic          reg_rd,           // Read strobe
    output logic      [DW-1:0] reg_rdata,        // Read data, cycle after strobe
    input  wire logic          stop_mode,        // Stop instruction in effect
    input  wire logic          ihs_tick,         // Internal high-speed enable pulse
    input  wire logic          xosc_tick,        // Resonator cell enable pulse
    input  wire logic          ext_clk_pin,      // Level on the external clock pin
    input  wire logic          sub_tick,         // Subsystem clock enable pulse
    output logic               osc_gain_sel,     // Resonator amplifier gain
    output logic               osc_run,          // Resonator oscillating
    output logic               ext_input_en,     // External clock input enabled
    output logic               port_pin_a_gpio,  // Pin A is a port
    output logic               port_pin_b_gpio,  // Pin B is a port
    output logic               main_clk_en,      // Main system clock pulse
    output logic               periph_clk_en,    // Peripheral clock pulse
    output logic               cpu_clk_en        // CPU clock pulse
);

    typedef struct packed {
        logic              ext_sel;
        logic              pin_sel;
        logic              gain;
        hsc_gain_e         gain_st;
        logic [HOLD_W-1:0] hold_cnt;
        logic              hs_stop;
        logic              main_src_sel;
        logic              main_mode;
        logic              main_stat;
        logic              cpu_src;
        logic              sub_flag;
        logic [2:0]        div_code;
        logic [STAB_W-1:0] stab_cnt;
        logic              ext_prev;
        logic [DW-1:0]     rdata;
        logic              main_en;
        logic              periph_en;
        logic              cpu_en;
        logic              osc_run;
        logic              ext_en;
        logic              pa_gpio;
        logic              pb_gpio;
    } hsc_state_s;

    localparam hsc_state_s RST_STATE = '{
        ext_sel:      1'b0,
        pin_sel:      1'b0,
        gain:         1'b0,
        gain_st:      HSC_GAIN_OPEN,
        hold_cnt:     '0,
        hs_stop:      RST_HS_CLOCK_STOP,
        main_src_sel: 1'b0,
        main_mode:    1'b0,
        main_stat:    1'b0,
        cpu_src:      1'b0,
        sub_flag:     1'b0,
        div_code:     RST_DIV_CODE,
        stab_cnt:     '0,
        ext_prev:     1'b0,
        rdata:        '0,
        main_en:      1'b0,
        periph_en:    1'b0,
        cpu_en:       1'b0,
        osc_run:      1'b0,
        ext_en:       1'b0,
        pa_gpio:      1'b1,
        pb_gpio:      1'b1
    };

    hsc_state_s s_r;
    hsc_state_s s_nxt;

    logic       hs_tick;
    logic       main_tick;
    logic       periph_tick;
    logic       cpu_div_tick;
    logic       hs_run;
    hsc_pin_e   pin_mode;
    logic [4:0] stab_status;

    // High-speed clock pulse from whichever pin source is enabled
    assign hs_tick = (s_r.osc_run & xosc_tick) | (s_r.ext_en & ext_clk_pin & ~s_r.ext_prev);

    // Stop bit or stop mode halts the high-speed source
    assign hs_run   = ~s_r.hs_stop & ~stop_mode;  // RL16
    assign pin_mode = hsc_pin_mode(s_r.ext_sel, s_r.pin_sel);

    // Main clock follows the confirmed source, never the request, so a switch
    // waits for the new source to deliver a pulse first
    assign main_tick = s_r.main_stat ? hs_tick : ihs_tick;  // RL17

    // Peripheral clock: high-speed when selected, and always when main is high-speed
    assign periph_tick = (s_r.main_src_sel | s_r.main_stat) ? hs_tick : ihs_tick;  // RL13

    // Stabilization status from raw counter bits 11, 13, 14, 15 and 16
    assign stab_status = {s_r.stab_cnt[STAB_E0], s_r.stab_cnt[STAB_E1],
                          s_r.stab_cnt[STAB_E2], s_r.stab_cnt[STAB_E3], s_r.stab_cnt[STAB_E4]};

    hsc_cpu_div u_div (
        .clock     (clock),
        .rst_b     (rst_b),
        .main_tick (main_tick),
        .div_code  (s_r.div_code),
        .div_tick  (cpu_div_tick)
    );

    // Next-state logic for registers, status and clock pulses
    always_comb begin
        s_nxt = s_r;
        s_nxt.ext_prev = ext_clk_pin;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                ADDR_OSC_MODE_CONTROL: begin
                    s_nxt.ext_sel = reg_wdata[BIT_EXT_INPUT_SEL];
                    s_nxt.pin_sel = reg_wdata[BIT_OSC_PIN_SEL];
                    // Gain accepts a single change; later changes are dropped
                    if (s_r.gain_st == HSC_GAIN_OPEN && reg_wdata[BIT_OSC_GAIN_SEL] != s_r.gain) begin  // RL2
                        s_nxt.gain     = reg_wdata[BIT_OSC_GAIN_SEL];  // RL1
                        s_nxt.hold_cnt = '0;
                        s_nxt.gain_st  = reg_wdata[BIT_OSC_GAIN_SEL] ? HSC_GAIN_HOLD : HSC_GAIN_LOCKED;  // RL3
                    end
                end
                ADDR_MAIN_OSC_CONTROL: begin
                    s_nxt.hs_stop = reg_wdata[BIT_HS_CLOCK_STOP];  // RL8
                end
                ADDR_MAIN_CLOCK_MODE: begin
                    s_nxt.main_src_sel = reg_wdata[BIT_MAIN_SRC_SEL];
                    s_nxt.main_mode    = reg_wdata[BIT_MAIN_CLK_MODE];
                end
                ADDR_CPU_CLOCK_CONTROL: begin
                    s_nxt.cpu_src = reg_wdata[BIT_CPU_SRC_SEL];
                    // Prohibited ratio codes are refused and the old ratio kept
                    if (hsc_div_ok(reg_wdata[DIV_MSB:DIV_LSB])) begin  // RL15
                        s_nxt.div_code = reg_wdata[DIV_MSB:DIV_LSB];
                    end
                end
                default: begin
                end
            endcase
        end

        // CPU hold window after the gain bit rises
        if (s_r.gain_st == HSC_GAIN_HOLD) begin
            if (s_r.hold_cnt == HOLD_W'(GAIN_HOLD_CYC - 1)) begin  // RL3
                s_nxt.gain_st = HSC_GAIN_LOCKED;
            end else begin
                s_nxt.hold_cnt = s_r.hold_cnt + 1'b1;
            end
        end

        // Pin use; ports unless the pin select bit claims them
        case (pin_mode)
            HSC_PIN_OSC: begin
                s_nxt.pa_gpio = 1'b0;  // RL6
                s_nxt.pb_gpio = 1'b0;
                s_nxt.osc_run = hs_run;  // RL8
                s_nxt.ext_en  = 1'b0;
            end
            HSC_PIN_EXT: begin
                s_nxt.pa_gpio = 1'b1;  // RL7
                s_nxt.pb_gpio = 1'b0;
                s_nxt.osc_run = 1'b0;
                s_nxt.ext_en  = hs_run;  // RL8
            end
            default: begin
                s_nxt.pa_gpio = 1'b1;  // RL5
                s_nxt.pb_gpio = 1'b1;
                s_nxt.osc_run = 1'b0;
                s_nxt.ext_en  = 1'b0;
            end
        endcase

        // Stabilization count restarts whenever the resonator is not running
        if (!s_r.osc_run) begin
            s_nxt.stab_cnt = '0;
        end else if (hs_tick && !s_r.stab_cnt[STAB_W-1]) begin
            s_nxt.stab_cnt = s_r.stab_cnt + 1'b1;
        end

        // Main source switch, taken only when the target source pulses
        if (s_r.main_src_sel && s_r.main_mode && !s_r.main_stat && hs_tick) begin  // RL12
            s_nxt.main_stat = 1'b1;
        end else if (!(s_r.main_src_sel && s_r.main_mode) && s_r.main_stat && ihs_tick) begin  // RL20
            s_nxt.main_stat = 1'b0;
        end

        // CPU source switch on a pulse of the source being entered
        if (s_r.cpu_src && !s_r.sub_flag && sub_tick) begin  // RL20
            s_nxt.sub_flag = 1'b1;
        end else if (!s_r.cpu_src && s_r.sub_flag && cpu_div_tick) begin  // RL14
            s_nxt.sub_flag = 1'b0;
        end

        // Clock pulses; CPU held off during the gain hold window
        s_nxt.main_en   = main_tick;
        s_nxt.periph_en = periph_tick;
        // The gain write cycle counts too, so no CPU pulse leaves beside the new gain
        if (s_r.gain_st == HSC_GAIN_HOLD || s_nxt.gain_st == HSC_GAIN_HOLD) begin
            s_nxt.cpu_en = 1'b0;  // RL3
        end else begin
            s_nxt.cpu_en = s_r.sub_flag ? sub_tick : cpu_div_tick;  // RL14
        end

        // Read data stands for the single cycle after the strobe
        s_nxt.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_OSC_MODE_CONTROL: begin
                    s_nxt.rdata[BIT_EXT_INPUT_SEL] = s_r.ext_sel;
                    s_nxt.rdata[BIT_OSC_PIN_SEL]   = s_r.pin_sel;
                    s_nxt.rdata[BIT_OSC_GAIN_SEL]  = s_r.gain;
                end
                ADDR_MAIN_OSC_CONTROL: begin
                    s_nxt.rdata[BIT_HS_CLOCK_STOP] = s_r.hs_stop;
                end
                ADDR_MAIN_CLOCK_MODE: begin
                    s_nxt.rdata[BIT_MAIN_SRC_SEL]  = s_r.main_src_sel;
                    s_nxt.rdata[BIT_MAIN_SRC_STAT] = s_r.main_stat;  // RL18
                    s_nxt.rdata[BIT_MAIN_CLK_MODE] = s_r.main_mode;
                end
                ADDR_CPU_CLOCK_CONTROL: begin
                    s_nxt.rdata[BIT_SUB_ACTIVE]    = s_r.sub_flag;  // RL18
                    s_nxt.rdata[BIT_CPU_SRC_SEL]   = s_r.cpu_src;
                    s_nxt.rdata[DIV_MSB:DIV_LSB]   = s_r.div_code;
                end
                ADDR_STAB_STATUS: begin
                    s_nxt.rdata[4:0] = stab_status;
                end
                default: begin
                    s_nxt.rdata = '0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata       = s_r.rdata;
    assign osc_gain_sel    = s_r.gain;
    assign osc_run         = s_r.osc_run;
    assign ext_input_en    = s_r.ext_en;
    assign port_pin_a_gpio = s_r.pa_gpio;
    assign port_pin_b_gpio = s_r.pb_gpio;
    assign main_clk_en     = s_r.main_en;
    assign periph_clk_en   = s_r.periph_en;
    assign cpu_clk_en      = s_r.cpu_en;

    // Cycles since the gain bit rose, saturating; only the checks read it
    logic [HOLD_W:0] since_gain;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            since_gain <= '1;
        end else if (s_nxt.gain && !s_r.gain) begin
            since_gain <= '0;
        end else if (!(&since_gain)) begin
            since_gain <= since_gain + 1'b1;
        end
    end

    AST_GAIN_ONCE: assert property (@(posedge clock) disable iff (!rst_b)  // RL2
        (s_r.gain_st != HSC_GAIN_OPEN) |=> $stable(s_r.gain))
        else $error("gain bit changed a second time");

    AST_CPU_HOLD: assert property (@(posedge clock) disable iff (!rst_b)  // RL3
        cpu_clk_en |-> (since_gain > (HOLD_W + 1)'(GAIN_HOLD_CYC)))
        else $error("cpu clock within the gain hold window");

    AST_PORT_MODE: assert property (@(posedge clock) disable iff (!rst_b)  // RL5
        !s_r.pin_sel |=> (port_pin_a_gpio && port_pin_b_gpio && !osc_run && !ext_input_en))
        else $error("pin left port mode without pin select");

    AST_OSC_MODE: assert property (@(posedge clock) disable iff (!rst_b)  // RL6
        (s_r.pin_sel && !s_r.ext_sel) |=> (!port_pin_a_gpio && !port_pin_b_gpio && !ext_input_en))
        else $error("oscillator mode pins wrong");

    AST_EXT_MODE: assert property (@(posedge clock) disable iff (!rst_b)  // RL7
        (s_r.pin_sel && s_r.ext_sel) |=> (port_pin_a_gpio && !port_pin_b_gpio && !osc_run))
        else $error("external input mode pins wrong");

    AST_START: assert property (@(posedge clock) disable iff (!rst_b)  // RL8
        (pin_mode == HSC_PIN_OSC && !s_r.hs_stop && !stop_mode) |=> osc_run)
        else $error("oscillator not started");

    AST_STOP: assert property (@(posedge clock) disable iff (!rst_b)  // RL16
        (s_r.hs_stop || stop_mode) |=> (!osc_run && !ext_input_en))
        else $error("high-speed source not halted");

    AST_PERIPH_HS: assert property (@(posedge clock) disable iff (!rst_b)  // RL13
        $past(s_r.main_stat) |-> (periph_clk_en == $past(hs_tick)))
        else $error("peripheral clock not high-speed");

    AST_DIV_LEGAL: assert property (@(posedge clock) disable iff (!rst_b)  // RL15
        hsc_div_ok(s_r.div_code))
        else $error("prohibited divider code accepted");

    AST_MAIN_STATUS: assert property (@(posedge clock) disable iff (!rst_b)  // RL18
        (reg_rd && reg_addr == ADDR_MAIN_CLOCK_MODE) |=> (reg_rdata[BIT_MAIN_SRC_STAT] == $past(s_r.main_stat)))
        else $error("main source status misread");

    AST_MAIN_SWITCH: assert property (@(posedge clock) disable iff (!rst_b)  // RL12
        $rose(s_r.main_stat) |-> $past(s_r.main_src_sel && s_r.main_mode))
        else $error("main source switched without both select bits");

endmodule

/* File: test/hsc_osc_model.sv */
`timescale 1ns/100ps
// Resonator and external clock source at the far side of the clock pins
module hsc_osc_model #(
    parameter int XOSC_DIV = 3,  // About 16.7 MHz, so high gain is needed
    parameter int EXT_DIV  = 4   // External clock period in system cycles
) (
    input  wire logic clock,         // System clock
    input  wire logic rst_b,         // Async reset, active low
    input  wire logic osc_run,       // Resonator enabled
    input  wire logic ext_input_en,  // External input enabled
    output logic      xosc_tick,     // Resonator pulse
    output logic      ext_clk_pin    // External clock level
);
    int cnt_r;

    // Idle pin toggles every cycle so that a stale level never looks valid
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r       <= 0;
            xosc_tick   <= 1'b0;
            ext_clk_pin <= 1'b0;
        end else begin
            cnt_r       <= (cnt_r + 1) % (XOSC_DIV * EXT_DIV);
            xosc_tick   <= osc_run && (cnt_r % XOSC_DIV == 0);
            ext_clk_pin <= ext_input_en ? (cnt_r % EXT_DIV < EXT_DIV / 2) : ~ext_clk_pin;
        end
    end
endmodule

/* File: test/high_speed_system_clock_control_tb.sv */
`timescale 1ns/100ps
module high_speed_system_clock_control_tb;
    import hsc_pkg::*;
    logic          clock, rst_b, reg_wr, reg_rd, stop_mode, ihs_tick, sub_tick;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata, reg_rdata, rd_v;
    logic          xosc_tick, ext_clk_pin, osc_gain_sel, osc_run, ext_input_en;
    logic          port_pin_a_gpio, port_pin_b_gpio, main_clk_en, periph_clk_en, cpu_clk_en;
    logic [31:0]   lfsr_r;
    logic [2:0]    code, cur;
    logic [2:0]    corner [4] = '{3'h4, 3'h0, 3'h5, 3'h7};
    int            miscompares, samples_checked, cpu, per, mn, n;

    hsc_top dut_u (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode),
        .ihs_tick(ihs_tick), .xosc_tick(xosc_tick), .ext_clk_pin(ext_clk_pin), .sub_tick(sub_tick),
        .osc_gain_sel(osc_gain_sel), .osc_run(osc_run), .ext_input_en(ext_input_en),
        .port_pin_a_gpio(port_pin_a_gpio), .port_pin_b_gpio(port_pin_b_gpio),
        .main_clk_en(main_clk_en), .periph_clk_en(periph_clk_en), .cpu_clk_en(cpu_clk_en));
    hsc_osc_model osc_u (.clock(clock), .rst_b(rst_b), .osc_run(osc_run),
        .ext_input_en(ext_input_en), .xosc_tick(xosc_tick), .ext_clk_pin(ext_clk_pin));

    // Free-running 50 MHz clock
    always #10 clock = ~clock;

    // Subsystem clock, one pulse in eight system cycles
    always @(posedge clock) sub_tick <= (($time / 20) % 8) == 0;

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk8(input logic [7:0] act, input logic [7:0] exp, input string what);
        samples_checked++;
        if (act !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, act, exp);
        end
    endtask

    task automatic chk_n(input int act, input int exp, input string what);
        samples_checked++;
        if (act != exp) begin
            miscompares++;
            $display("wrong value at %0t: %s count %0d expected %0d", $time, what, act, exp);
        end
    endtask

    // Register port: one-cycle strobes, read data in the following cycle only
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask

    task automatic ticks(input int k);
        repeat (k) @(negedge clock);
    endtask

    // Pulse counts over a window; windows are whole periods so counts are exact
    task automatic count(input int k);
        cpu = 0;
        per = 0;
        mn  = 0;
        repeat (k) begin
            @(negedge clock);
            if (cpu_clk_en === 1'b1) cpu++;
            if (periph_clk_en === 1'b1) per++;
            if (main_clk_en === 1'b1) mn++;
        end
    endtask

    task automatic poll_status(input logic want);
        n = 0;
        do begin
            rd(ADDR_MAIN_CLOCK_MODE, rd_v);
            n++;
        end while (rd_v[BIT_MAIN_SRC_STAT] !== want && n < 20);
    endtask

    // Run main, peripheral and CPU (code 0) from the high-speed clock, then return
    task automatic hs_main(input int period);
        wr(ADDR_MAIN_CLOCK_MODE, 8'h05);
        poll_status(1'b1);
        chk8(rd_v, 8'h07, "mode status hs");
        count(120);
        chk_n(mn, 120 / period, "main hs");
        chk_n(per, 120 / period, "periph hs");
        chk_n(cpu, 120 / period, "cpu hs");
        wr(ADDR_MAIN_CLOCK_MODE, 8'h00);
        poll_status(1'b0);
        chk8(rd_v, 8'h00, "mode status internal");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 10k cycles
    initial begin
        #1000000;
        miscompares++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        clock = 0; rst_b = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
        stop_mode = 0; ihs_tick = 1; lfsr_r = 32'h838c; cur = 3'h1;
        miscompares = 0; samples_checked = 0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        ticks(1);
        chk8({6'h00, port_pin_a_gpio, port_pin_b_gpio}, 8'h03, "pins port");
        chk8({5'h00, osc_run, ext_input_en, osc_gain_sel}, 8'h00, "osc off");
        rd(ADDR_MAIN_OSC_CONTROL, rd_v);
        chk8(rd_v, 8'h80, "stop bit");
        rd(ADDR_CPU_CLOCK_CONTROL, rd_v);
        chk8(rd_v, 8'h01, "cpu ctl");
        rd(ADDR_MAIN_CLOCK_MODE, rd_v);
        chk8(rd_v, 8'h00, "mode");
        rd(3'h7, rd_v);
        chk8(rd_v, 8'h00, "unmapped");
        count(160);
        chk_n(cpu, 80, "cpu default");
        // Gain first, as software must; then a second change is ignored
        wr(ADDR_OSC_MODE_CONTROL, 8'h01);
        count(240);
        chk_n(cpu, 0, "cpu held");
        wr(ADDR_OSC_MODE_CONTROL, 8'h00);
        rd(ADDR_OSC_MODE_CONTROL, rd_v);
        chk8({rd_v[0], osc_gain_sel}, 8'h03, "gain locked");
        // Divider: corners then random codes; prohibited codes leave the ratio
        for (int i = 0; i < 12; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            code = (i < 4) ? corner[i] : lfsr_r[2:0];
            if (code <= DIV_MAX_CODE) cur = code;
            wr(ADDR_CPU_CLOCK_CONTROL, {5'h00, code});
            ticks(40);
            rd(ADDR_CPU_CLOCK_CONTROL, rd_v);
            chk8(rd_v, {5'h00, cur}, "div code");
            count(160);
            chk_n(cpu, 160 >> cur, "cpu div");
        end
        // CPU from the subsystem clock, then back to the main clock
        wr(ADDR_CPU_CLOCK_CONTROL, 8'h10);
        ticks(40);
        rd(ADDR_CPU_CLOCK_CONTROL, rd_v);
        chk8(rd_v, 8'h30, "sub flag");
        count(160);
        chk_n(cpu, 20, "cpu sub");
        wr(ADDR_CPU_CLOCK_CONTROL, 8'h00);
        // Resonator mode
        wr(ADDR_OSC_MODE_CONTROL, 8'h41);
        ticks(2);
        chk8({6'h00, port_pin_a_gpio, port_pin_b_gpio}, 8'h00, "pins osc");
        chk8({7'h00, osc_run}, 8'h00, "osc still stopped");
        wr(ADDR_MAIN_OSC_CONTROL, 8'h00);
        ticks(2);
        chk8({7'h00, osc_run}, 8'h01, "osc run");
        n = 0;
        do begin
            rd(ADDR_STAB_STATUS, rd_v);
            n++;
        end while (rd_v[4] !== 1'b1 && n < 4000);
        chk8(rd_v & 8'h11, 8'h10, "stab status");
        hs_main(3);
        wr(ADDR_MAIN_OSC_CONTROL, 8'h80);
        ticks(2);
        chk8({7'h00, osc_run}, 8'h00, "osc stop");
        // External input mode
        wr(ADDR_OSC_MODE_CONTROL, 8'hC1);
        ticks(2);
        chk8({6'h00, port_pin_a_gpio, port_pin_b_gpio}, 8'h02, "pins ext");
        wr(ADDR_MAIN_OSC_CONTROL, 8'h00);
        ticks(2);
        chk8({6'h00, ext_input_en, osc_run}, 8'h02, "ext on");
        hs_main(4);
        @(posedge clock);
        stop_mode <= 1'b1;
        ticks(3);
        chk8({7'h00, ext_input_en}, 8'h00, "stop mode");
        end_of_test();
    end
endmodule
